// file: core/grs_pkg.sv
// Purpose: constants and types for the gas result and status register bank
// Assumes: one 10 MHz clock, byte-wide register port
// Notes: offsets are byte addresses on the register port
//
// Overview of operation
// RULE1 - result is signed 16-bit, one count per ppm
// RULE2 - both result bytes load at sequence end only
// RULE3 - reading low result byte clears new-result flag
// RULE4 - host reads high byte before low byte
// RULE5 - new-result flag sets each sequence end, sticky
// RULE6 - latching condition at sequence end sets irq flag
// RULE7 - write one bit1 clears irq flag, pin inactive
// RULE8 - write one bit0 clears threshold alarm flag
// RULE9 - threshold violation at sequence end sets alarm
// RULE10 - both clear bits read back as zero
// RULE11 - bits 7:6 read zero, bit5 reserved read-only
// RULE12 - status writes only act through clear bits
// RULE13 - flag set beats simultaneous clear
// RULE14 - mode 01 starts one sequence, 10 repeats
// RULE15 - pin function 010 ready, 001 alarm
package grs_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] ADDR_MODE_CFG = 8'h04;
  localparam logic [7:0] ADDR_RES_HI = 8'h05;
  localparam logic [7:0] ADDR_RES_LO = 8'h06;
  localparam logic [7:0] ADDR_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h08;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int FLG_THRESHOLD_ALARM_CLEAR = 0;
  localparam int FLG_IRQ_CLR = 1;
  localparam int PIN_TYP_BIT = 4;
  localparam int STK_ALARM = 0;
  localparam int STK_IRQ = 1;
  localparam int STK_NEW = 2;
  localparam int STK_PIN = 3;
  localparam int STK_N = 4;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_MODE_CFG = 8'h24;
  localparam logic [4:0] RST_PIN_CFG = 5'h00;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic RST_PIN_LEVEL = 1'h1;

  // ***************************************************************
  // codes
  // ***************************************************************
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [2:0] FUNC_ALARM = 3'h1;
  localparam logic [2:0] FUNC_READY = 3'h2;
  localparam logic [2:0] FUNC_BUSY = 3'h3;
  localparam logic [2:0] FUNC_EARLY = 3'h4;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CONT_PERIOD_S = 60;
  localparam int unsigned CONT_PERIOD_CYC = CONT_PERIOD_S * CLK_HZ;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RUN = 3'b010,
    SEQ_WAIT = 3'b100
  } grs_seq_t;

endpackage : grs_pkg

// file: core/grs_sticky.sv
// Purpose: vector of sticky flags with per-bit set and clear
// Assumes: set and clear are single-cycle strobes
// Notes: set has priority over clear
`timescale 1ns/1ps
module grs_sticky #(
  parameter int N = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_q
);

  // ***************************************************************
  // one flop per flag
  // ***************************************************************
  for (genvar g = 0; g < N; g++) begin : g_flag
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        o_q[g] <= 1'h0;
      end else if (i_ce) begin
        if (i_set[g]) begin
          o_q[g] <= 1'h1; // RULE13
        end else if (i_clr[g]) begin
          o_q[g] <= 1'h0;
        end
      end
    end
  end

endmodule : grs_sticky

// file: core/grs_regs.sv
// Purpose: result bytes, measurement flags, mode and pin logic
// Assumes: measurement engine pulses i_seq_done with result and hit
// Notes: register reads answer one cycle after the read strobe
`timescale 1ns/1ps
module grs_regs
  import grs_pkg::*;
#(
  parameter int unsigned P_PERIOD_CYC = CONT_PERIOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_seq_done,
  input wire logic [15:0] i_seq_result,
  input wire logic i_threshold_hit,
  output logic o_seq_start,
  output logic o_int_pin
);

  // ***************************************************************
  // state
  // ***************************************************************
  grs_seq_t seq_q;
  grs_seq_t seq_d;
  logic [7:0] mode_cfg_q;
  logic [7:0] mode_cfg_d;
  logic [4:0] pin_cfg_q;
  logic [15:0] result_q;
  logic [7:0] shadow_lo_q;
  logic shadow_vld_q;
  logic [31:0] period_q;
  logic [31:0] period_d;
  logic [STK_N-1:0] flag_set;
  logic [STK_N-1:0] flag_clr;
  logic [STK_N-1:0] flag_q;

  // ***************************************************************
  // address decode
  // ***************************************************************
  wire logic wr_mode = i_reg_wr && (i_reg_addr == ADDR_MODE_CFG);
  wire logic wr_flags = i_reg_wr && (i_reg_addr == ADDR_FLAGS);
  wire logic wr_pin = i_reg_wr && (i_reg_addr == ADDR_PIN_CFG);
  wire logic rd_hi = i_reg_rd && (i_reg_addr == ADDR_RES_HI);
  wire logic rd_lo = i_reg_rd && (i_reg_addr == ADDR_RES_LO);
  wire logic rd_mode = i_reg_rd && (i_reg_addr == ADDR_MODE_CFG);
  wire logic rd_flags = i_reg_rd && (i_reg_addr == ADDR_FLAGS);
  wire logic rd_pin = i_reg_rd && (i_reg_addr == ADDR_PIN_CFG);

  // ***************************************************************
  // mode and sequence events
  // ***************************************************************
  wire logic [1:0] operating_mode_field = mode_cfg_q[1:0];
  wire logic [2:0] pin_func = pin_cfg_q[3:1];
  wire logic pin_typ = pin_cfg_q[PIN_TYP_BIT];
  // a done pulse outside a running sequence is ignored
  wire logic seq_end = i_seq_done && (seq_q == SEQ_RUN);
  // reserved mode code behaves as idle, so it is stored as idle
  wire logic [1:0] wr_op = (i_reg_wdata[1:0] == MODE_RSVD) ? MODE_IDLE : i_reg_wdata[1:0];
  wire logic period_done = (period_q == 32'h00000000);
  wire logic [31:0] period_load = 32'(P_PERIOD_CYC - 1);

  always_comb begin
    mode_cfg_d = mode_cfg_q;
    if (wr_mode) begin
      mode_cfg_d = {i_reg_wdata[7:2], wr_op}; // RULE14
    end else if (seq_end && (operating_mode_field == MODE_SINGLE)) begin
      mode_cfg_d = {mode_cfg_q[7:2], MODE_IDLE}; // RULE14
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  logic start_d;

  always_comb begin
    seq_d = seq_q;
    start_d = 1'h0;
    unique case (seq_q)
      SEQ_IDLE: begin
        if (operating_mode_field != MODE_IDLE) begin
          seq_d = SEQ_RUN; // RULE14
          start_d = 1'h1;
        end
      end
      SEQ_RUN: begin
        if (i_seq_done) begin
          seq_d = (operating_mode_field == MODE_CONT) ? SEQ_WAIT : SEQ_IDLE;
        end
      end
      SEQ_WAIT: begin
        if (operating_mode_field == MODE_IDLE) begin
          seq_d = SEQ_IDLE;
        end else if (period_done || (operating_mode_field == MODE_SINGLE)) begin
          seq_d = SEQ_RUN; // RULE14
          start_d = 1'h1;
        end
      end
      default: begin
        seq_d = SEQ_IDLE;
      end
    endcase
  end

  // period runs from each start so the spacing of starts is fixed
  always_comb begin
    period_d = period_q;
    if (start_d) begin
      period_d = period_load;
    end else if (!period_done) begin
      period_d = period_q - 32'h00000001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_q <= SEQ_IDLE;
      period_q <= 32'h00000000;
      o_seq_start <= 1'h0;
    end else if (i_ce) begin
      seq_q <= seq_d;
      period_q <= period_d;
      o_seq_start <= start_d;
    end
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_cfg_q <= RST_MODE_CFG;
      pin_cfg_q <= RST_PIN_CFG;
    end else if (i_ce) begin
      mode_cfg_q <= mode_cfg_d;
      if (wr_pin) begin
        pin_cfg_q <= i_reg_wdata[4:0];
      end
    end
  end

  // ***************************************************************
  // result bytes
  // ***************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      result_q <= RST_RESULT;
    end else if (i_ce && seq_end) begin
      result_q <= i_seq_result; // RULE1 RULE2
    end
  end

  // low byte frozen at the high-byte read so a result landing
  // between the two reads cannot tear the pair
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      shadow_lo_q <= 8'h00;
      shadow_vld_q <= 1'h0;
    end else if (i_ce) begin
      if (rd_hi) begin
        shadow_lo_q <= result_q[7:0]; // RULE4
        shadow_vld_q <= 1'h1;
      end else if (rd_lo) begin
        shadow_vld_q <= 1'h0;
      end
    end
  end

  wire logic [7:0] lo_view = shadow_vld_q ? shadow_lo_q : result_q[7:0];

  // ***************************************************************
  // sticky flags
  // ***************************************************************
  wire logic latch_cond = seq_end
      && (((pin_func == FUNC_ALARM) && i_threshold_hit) // RULE15
      || (pin_func == FUNC_READY)); // RULE15

  assign flag_set[STK_ALARM] = seq_end && i_threshold_hit; // RULE9
  assign flag_set[STK_IRQ] = latch_cond; // RULE6
  assign flag_set[STK_NEW] = seq_end; // RULE5
  assign flag_set[STK_PIN] = latch_cond; // RULE6

  // only the two clear bits of a status write do anything
  assign flag_clr[STK_ALARM] = wr_flags && i_reg_wdata[FLG_THRESHOLD_ALARM_CLEAR]; // RULE8 RULE12
  assign flag_clr[STK_IRQ] = wr_flags && i_reg_wdata[FLG_IRQ_CLR]; // RULE7 RULE12
  assign flag_clr[STK_NEW] = rd_lo; // RULE3
  // changing pin setup also drops the pin to inactive
  assign flag_clr[STK_PIN] = (wr_flags && i_reg_wdata[FLG_IRQ_CLR]) || wr_pin; // RULE7

  grs_sticky #(
    .N(STK_N)
  ) u_flags (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_q(flag_q)
  );

  // ***************************************************************
  // notification pin
  // ***************************************************************
  wire logic early_act = (operating_mode_field == MODE_CONT) && start_d;
  wire logic pin_act =
      ((pin_func == FUNC_ALARM) && flag_q[STK_PIN]) ||
      ((pin_func == FUNC_READY) && flag_q[STK_PIN]) ||
      ((pin_func == FUNC_BUSY) && (seq_q == SEQ_RUN)) ||
      ((pin_func == FUNC_EARLY) && early_act);
  // typ clear means active low
  wire logic pin_level = pin_typ ? pin_act : !pin_act;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_pin <= RST_PIN_LEVEL;
    end else if (i_ce) begin
      o_int_pin <= pin_level;
    end
  end

  // ***************************************************************
  // read data
  // ***************************************************************
  wire logic [7:0] flags_view = {2'h0, 1'h0, // RULE11
      flag_q[STK_NEW], flag_q[STK_IRQ], flag_q[STK_ALARM],
      2'h0}; // RULE10
  wire logic [7:0] rdata_d =
      rd_hi ? result_q[15:8] :
      rd_lo ? lo_view :
      rd_flags ? flags_view :
      rd_mode ? mode_cfg_q :
      rd_pin ? {3'h0, pin_cfg_q} :
      8'h00;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'h0;
    end else if (i_ce) begin
      o_reg_rdata <= rdata_d;
      o_reg_rvalid <= i_reg_rd;
    end
  end

endmodule : grs_regs

// file: verif/grs_regs_monitor.sv
// Purpose: checker for the gas result and status registers
// Assumes: sees only grs_regs ports
// Notes: flag checks read status one or two cycles after the cause
`timescale 1ns/1ps
module grs_regs_chk
  import grs_pkg::*;
#(
  parameter int unsigned P_PERIOD_CYC = CONT_PERIOD_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic i_seq_done,
  input wire logic [15:0] i_seq_result,
  input wire logic i_threshold_hit,
  input wire logic o_seq_start,
  input wire logic o_int_pin
);
  // ****
  // helpers
  // ****
  logic run_q;
  logic typ_q;
  wire rd_f = i_ce & i_reg_rd & (i_reg_addr == ADDR_FLAGS);
  wire rd_l = i_ce & i_reg_rd & (i_reg_addr == ADDR_RES_LO);
  wire rd_h = i_ce & i_reg_rd & (i_reg_addr == ADDR_RES_HI);
  wire wr_f = i_ce & i_reg_wr & (i_reg_addr == ADDR_FLAGS);
  // done outside a run is ignored, so only count ends of real runs
  wire fin = i_ce & i_seq_done & run_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
      typ_q <= 1'b0;
    end else if (i_ce) begin
      run_q <= o_seq_start | (run_q & ~i_seq_done);
      if (i_reg_wr && i_reg_addr == ADDR_PIN_CFG) begin
        typ_q <= i_reg_wdata[PIN_TYP_BIT];
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_status_fixed_zero: assert property (
    rd_f |=> o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[1:0] == 2'h0) else $error("status zeros");
  a_new_on_end: assert property (
    fin ##1 rd_f |=> o_reg_rdata[4]) else $error("new flag not set");
  a_alarm_on_hit: assert property (
    fin && i_threshold_hit ##1 rd_f |=> o_reg_rdata[2]) else $error("alarm not set");
  a_low_read_clears: assert property (
    rd_l && !fin ##1 !fin ##1 rd_f && !fin |=> !o_reg_rdata[4]) else $error("new not cleared");
  a_alarm_clear: assert property (
    wr_f && i_reg_wdata[0] && !fin ##1 !fin ##1 rd_f && !fin |=> !o_reg_rdata[2])
    else $error("alarm kept");
  a_irq_clear: assert property (
    wr_f && i_reg_wdata[1] && !fin ##1 !fin ##1 rd_f && !fin && !run_q
    |=> !o_reg_rdata[3] && o_int_pin == !typ_q) else $error("irq kept");
  a_set_beats_clear: assert property (
    fin && rd_l ##1 !rd_l ##1 rd_f |=> o_reg_rdata[4]) else $error("set lost");
  a_result_holds: assert property (
    rd_h && !fin ##1 !fin ##1 rd_h |=> o_reg_rdata == $past(o_reg_rdata, 2))
    else $error("result moved");
  c_end: cover property (fin);
  c_end_clear: cover property (fin && rd_l);
  c_irq_clear: cover property (wr_f && i_reg_wdata[1]);
endmodule : grs_regs_chk

bind grs_regs grs_regs_chk #(.P_PERIOD_CYC(P_PERIOD_CYC)) chk_u (.*);

// file: verif/grs_engine_model.sv
// Purpose: measurement engine stand-in
// Assumes: one done pulse for each start pulse
// Notes: result lines carry inverted data outside done
`timescale 1ns/1ps
module grs_engine_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [15:0] i_value,
  input wire logic i_hit,
  input wire logic [7:0] i_delay,
  output logic o_done,
  output logic [15:0] o_result,
  output logic o_hit
);
  initial begin
    o_done = 1'b0;
    o_result = 16'hFFFF;
    o_hit = 1'b0;
    forever begin
      // looked at mid-cycle, never in the step of the edge that launches it
      @(negedge i_clk);
      if (i_start === 1'b1) begin
        repeat (i_delay + 8'h01) @(negedge i_clk);
        o_done = 1'b1;
        o_result = i_value;
        o_hit = i_hit;
        @(negedge i_clk);
        o_done = 1'b0;
        o_result = ~i_value;
        o_hit = ~i_hit;
      end
    end
  end
endmodule : grs_engine_model

// file: verif/tb_grs_regs.sv
// Purpose: self-checking bench for the gas result and status registers
// Assumes: engine model answers each start
// Notes: reads and writes take two cycles each
`timescale 1ns/1ps
module tb_grs_regs;
  import grs_pkg::*;
  logic i_clk, i_rst, i_reg_wr, i_reg_rd, o_reg_rvalid, o_seq_start, o_int_pin;
  logic done, hit, e_hit, ce;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, dly;
  logic [15:0] res, val;
  int bad_count = 0;
  int total_checks = 0;
  grs_regs #(.P_PERIOD_CYC(50)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_seq_done(done), .i_seq_result(res), .i_threshold_hit(hit),
    .o_seq_start(o_seq_start), .o_int_pin(o_int_pin));
  grs_engine_model eng_u (.i_clk(i_clk), .i_start(o_seq_start), .i_value(val),
    .i_hit(e_hit), .i_delay(dly), .o_done(done), .o_result(res), .o_hit(hit));
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    // idle cycle keeps back-to-back strobes apart
    @(negedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, o_reg_rvalid});
    chk($sformatf("reg %h", a), e, o_reg_rdata);
    @(negedge i_clk);
  endtask : rd
  // single shot, returns in the falling edge before the done edge
  task automatic measure(input logic [15:0] v, input logic h, input logic [7:0] d);
    val = v;
    e_hit = h;
    dly = d;
    wr(ADDR_MODE_CFG, 8'h01);
    @(posedge done);
  endtask : measure
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    bad_count++;
    $display("Error watchdog expired");
    finish_test;
  end
  initial begin
    i_rst = 1'b1;
    ce = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    val = 16'h0000;
    e_hit = 1'b0;
    dly = 8'h00;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    rd(ADDR_RES_HI, 8'h00);
    rd(ADDR_RES_LO, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    rd(ADDR_MODE_CFG, 8'h24);
    rd(8'h0F, 8'h00);
    chk("pin", 8'h01, {7'h00, o_int_pin});
    $display("test reset done");
    wr(ADDR_PIN_CFG, 8'h04);
    measure(16'h8123, 1'b1, 8'h14);
    @(negedge i_clk);
    rd(ADDR_FLAGS, 8'h1C);
    chk("pin", 8'h00, {7'h00, o_int_pin});
    rd(ADDR_MODE_CFG, 8'h00);
    rd(ADDR_RES_HI, 8'h81);
    rd(ADDR_RES_HI, 8'h81);
    rd(ADDR_RES_LO, 8'h23);
    rd(ADDR_FLAGS, 8'h0C);
    $display("test measure done");
    rd(ADDR_RES_HI, 8'h81);
    wr(ADDR_RES_HI, 8'hFF);
    wr(ADDR_RES_LO, 8'hFF);
    rd(ADDR_RES_HI, 8'h81);
    wr(ADDR_FLAGS, 8'hFC);
    rd(ADDR_FLAGS, 8'h0C);
    // frozen clock enable: the clear must not act
    ce = 1'b0;
    wr(ADDR_FLAGS, 8'h01);
    ce = 1'b1;
    rd(ADDR_FLAGS, 8'h0C);
    wr(ADDR_FLAGS, 8'h01);
    rd(ADDR_FLAGS, 8'h08);
    wr(ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h00);
    chk("pin", 8'h01, {7'h00, o_int_pin});
    $display("test clear done");
    wr(ADDR_PIN_CFG, 8'h02);
    measure(16'h0123, 1'b1, 8'h00);
    rd(ADDR_RES_LO, 8'h23);
    rd(ADDR_FLAGS, 8'h1C);
    chk("pin", 8'h00, {7'h00, o_int_pin});
    rd(ADDR_RES_HI, 8'h01);
    rd(ADDR_RES_LO, 8'h23);
    $display("test overlap done");
    wr(ADDR_FLAGS, 8'h03);
    wr(ADDR_PIN_CFG, 8'h16);
    chk("pin", 8'h00, {7'h00, o_int_pin});
    val = 16'hFF38;
    e_hit = 1'b0;
    dly = 8'h05;
    wr(ADDR_MODE_CFG, 8'h02);
    @(posedge done);
    chk("pin", 8'h01, {7'h00, o_int_pin});
    @(posedge done);
    rd(ADDR_MODE_CFG, 8'h02);
    rd(ADDR_FLAGS, 8'h10);
    rd(ADDR_RES_HI, 8'hFF);
    rd(ADDR_RES_LO, 8'h38);
    wr(ADDR_MODE_CFG, 8'h00);
    chk("pin", 8'h00, {7'h00, o_int_pin});
    $display("test continuous done");
    finish_test;
  end
endmodule : tb_grs_regs
